//--- src/spm_pkg.sv
// Operation
// RQ1 - Control bit 2 picks role: 0 makes the port master, 1 slave.
// RQ2 - Software changes the role bit only while the port is disabled.
// RQ3 - Control bit 1 enables the port; 0 stops all serial operation.
// RQ4 - Software clears the enable before reprogramming any control register.
// RQ5 - Bit 3 set in slave role: the transmit pin is never driven.
// RQ6 - With tied transmit lines the master enables only one slave's output.
// RQ7 - Bits 31 to 4 are read-only; software leaves them unchanged.
// RQ8 - Bit 0 set routes transmit shifter output into the receive shifter.
// RQ9 - Disabling the port does not empty the transmit or receive queues.
// RQ10 - While disabled, no frames start; clock and frame outputs stay idle.
`default_nettype none
package spm_pkg;
  localparam logic [11:0] CTRL_ONE_OFFSET = 12'h004;
  localparam int          LOOPBACK_BIT    = 0;
  localparam int          ENABLE_BIT      = 1;
  localparam int          ROLE_BIT        = 2;
  localparam int          SOD_BIT         = 3;
  localparam int          CTRL_WIDTH      = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam int          DATA_BITS       = 8;
  localparam logic [7:0]  CLK_DIV         = 8'h04;
endpackage
`default_nettype wire

//--- src/spm_shifter.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Serial engine: fixed mode 0, MSB first; master or slave as selected
module spm_shifter #(
  parameter int NBITS = spm_pkg::DATA_BITS
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             enable,
  input  wire logic             slave_role,
  input  wire logic             loopback,
  input  wire logic             slave_output_disable,
  // Word exchange
  input  wire logic             tx_valid,
  input  wire logic [NBITS-1:0] tx_word,
  output logic                  tx_ready,
  output logic                  rx_valid,
  output logic      [NBITS-1:0] rx_word,
  output logic                  busy,
  // Serial pins
  output logic                  sclk_o,
  output logic                  sclk_oe_n,
  input  wire logic             sclk_i,
  output logic                  frame_o,
  output logic                  frame_oe_n,
  input  wire logic             frame_i,
  output logic                  tx_o,
  output logic                  tx_oe_n,
  input  wire logic             rx_i
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} spm_state_e;
  localparam int CW = $clog2(NBITS + 1);

  spm_state_e       state, next_state;
  logic [7:0]       div, next_div;
  logic [CW-1:0]    cnt, next_cnt;
  logic [NBITS-1:0] txsh, next_txsh;
  logic [NBITS-1:0] rxsh, next_rxsh;
  logic             sck_q, next_sck_q;
  logic             fr_q, next_fr_q;
  logic             rxv, next_rxv;
  logic [NBITS-1:0] rxw, next_rxw;
  logic             sin;
  logic             tick;

  // Loopback takes the serial input straight from our own shifter
  assign sin  = loopback ? txsh[NBITS-1] : rx_i; // RQ8
  assign tick = (div == spm_pkg::CLK_DIV - 8'h01);

  always_comb
  begin
    next_state = state;
    next_div   = div;
    next_cnt   = cnt;
    next_txsh  = txsh;
    next_rxsh  = rxsh;
    next_sck_q = sck_q;
    next_fr_q  = fr_q;
    next_rxv   = 1'b0;
    next_rxw   = rxw;
    tx_ready   = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_div = 8'h00;
        // Master starts frames only when enabled and data waits
        if (enable && !slave_role && tx_valid) // RQ3 RQ10
        begin
          tx_ready   = 1'b1;
          next_txsh  = tx_word;
          next_cnt   = CW'(NBITS);
          next_fr_q  = 1'b0;
          next_state = ST_LOW;
        end
        else if (enable && slave_role && !frame_i) // RQ1
        begin
          tx_ready   = tx_valid;
          next_txsh  = tx_valid ? tx_word : '0;
          next_cnt   = CW'(NBITS);
          next_state = ST_LOW;
        end
      end
      ST_LOW, ST_HIGH:
      begin
        if (!enable)
        begin
          // Disable aborts the frame; queued words outside stay put
          next_state = ST_IDLE; // RQ3 RQ9
          next_sck_q = 1'b0;
          next_fr_q  = 1'b1;
        end
        else if (slave_role)
        begin
          if (frame_i)
            next_state = ST_IDLE;
          else if (state == ST_LOW && sclk_i)
          begin
            next_rxsh  = {rxsh[NBITS-2:0], sin};
            next_state = ST_HIGH;
          end
          else if (state == ST_HIGH && !sclk_i)
          begin
            next_txsh = {txsh[NBITS-2:0], 1'b0};
            next_cnt  = cnt - CW'(1);
            if (cnt == CW'(1))
            begin
              next_rxv   = 1'b1;
              next_rxw   = rxsh;
              next_state = ST_IDLE;
            end
            else
              next_state = ST_LOW;
          end
        end
        else
        begin
          next_div = tick ? 8'h00 : div + 8'h01;
          if (tick && state == ST_LOW)
          begin
            next_sck_q = 1'b1;
            next_rxsh  = {rxsh[NBITS-2:0], sin};
            next_state = ST_HIGH;
          end
          else if (tick)
          begin
            next_sck_q = 1'b0;
            next_txsh  = {txsh[NBITS-2:0], 1'b0};
            next_cnt   = cnt - CW'(1);
            if (cnt == CW'(1))
            begin
              next_rxv   = 1'b1;
              next_rxw   = rxsh;
              next_fr_q  = 1'b1;
              next_state = ST_IDLE;
            end
            else
              next_state = ST_LOW;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      div   <= 8'h00;
      cnt   <= '0;
      txsh  <= '0;
      rxsh  <= '0;
      sck_q <= 1'b0;
      fr_q  <= 1'b1;
      rxv   <= 1'b0;
      rxw   <= '0;
    end
    else
    begin
      state <= next_state;
      div   <= next_div;
      cnt   <= next_cnt;
      txsh  <= next_txsh;
      rxsh  <= next_rxsh;
      sck_q <= next_sck_q;
      fr_q  <= next_fr_q;
      rxv   <= next_rxv;
      rxw   <= next_rxw;
    end
  end

  assign rx_valid   = rxv;
  assign rx_word    = rxw;
  assign busy       = (state != ST_IDLE);
  assign sclk_o     = sck_q;
  assign frame_o    = fr_q;
  assign sclk_oe_n  = slave_role;
  assign frame_oe_n = slave_role;
  assign tx_o       = txsh[NBITS-1];
  // Slave with output disable never drives; loopback keeps the pin quiet too
  assign tx_oe_n    = loopback || !enable || (slave_role && (slave_output_disable || frame_i)); // RQ5 RQ8

  property p_sod_quiet;
    @(posedge pclk) disable iff (!presetn) (slave_role && slave_output_disable) |-> tx_oe_n;
  endproperty
  a_sod_quiet: assert property (p_sod_quiet) else $error("slave drove transmit pin"); // RQ5
endmodule
`default_nettype wire

//--- src/spm_top.sv
`timescale 1ns/1ps
`default_nettype none
// APB slave holding the second control register and driving the serial engine
module spm_top #(
  parameter int NBITS = spm_pkg::DATA_BITS
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Word source and sink
  input  wire logic             tx_valid,
  input  wire logic [NBITS-1:0] tx_word,
  output logic                  tx_ready,
  output logic                  rx_valid,
  output logic      [NBITS-1:0] rx_word,
  output logic                  busy,
  // Serial pins
  output logic             sclk_o,
  output logic             sclk_oe_n,
  input  wire logic        sclk_i,
  output logic             frame_o,
  output logic             frame_oe_n,
  input  wire logic        frame_i,
  output logic             tx_o,
  output logic             tx_oe_n,
  input  wire logic        rx_i
);
  logic [spm_pkg::CTRL_WIDTH-1:0] ctrl, next_ctrl;
  logic [31:0]                    rdq, next_rdq;
  logic                           hit, wr, rd;

  assign hit = (paddr == spm_pkg::CTRL_ONE_OFFSET);
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && !penable && !pwrite;

  always_comb
  begin
    next_ctrl = ctrl;
    next_rdq  = rdq;
    // Only bits 3:0 are stored; upper bits ignore writes
    if (wr && hit)
      next_ctrl = pwdata[spm_pkg::CTRL_WIDTH-1:0]; // RQ1 RQ3 RQ7
    if (rd)
      next_rdq = hit ? {28'h0000000, ctrl} : 32'h00000000; // RQ7
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= spm_pkg::CTRL_RESET;
      rdq  <= 32'h00000000;
    end
    else
    begin
      ctrl <= next_ctrl;
      rdq  <= next_rdq;
    end
  end

  assign prdata  = rdq;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  spm_shifter #(
    .NBITS(NBITS)
  ) u_shift (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (ctrl[spm_pkg::ENABLE_BIT]),
    .slave_role(ctrl[spm_pkg::ROLE_BIT]),
    .loopback  (ctrl[spm_pkg::LOOPBACK_BIT]),
    .slave_output_disable       (ctrl[spm_pkg::SOD_BIT]),
    .tx_valid  (tx_valid),
    .tx_word   (tx_word),
    .tx_ready  (tx_ready),
    .rx_valid  (rx_valid),
    .rx_word   (rx_word),
    .busy      (busy),
    .sclk_o    (sclk_o),
    .sclk_oe_n (sclk_oe_n),
    .sclk_i    (sclk_i),
    .frame_o   (frame_o),
    .frame_oe_n(frame_oe_n),
    .frame_i   (frame_i),
    .tx_o      (tx_o),
    .tx_oe_n   (tx_oe_n),
    .rx_i      (rx_i)
  );

  property p_write_takes;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit) |=> (ctrl == $past(pwdata[spm_pkg::CTRL_WIDTH-1:0]));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("write lost"); // RQ3

  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn) prdata[31:4] == 28'h0000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set"); // RQ7

  property p_disabled_idle;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl[spm_pkg::ENABLE_BIT] && !busy) |-> (frame_o && !sclk_o && !tx_ready);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("activity while off"); // RQ10

  property p_abort;
    @(posedge pclk) disable iff (!presetn) (!ctrl[spm_pkg::ENABLE_BIT] && busy) |=> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not stopped"); // RQ3

  property p_master_drives;
    @(posedge pclk) disable iff (!presetn) !ctrl[spm_pkg::ROLE_BIT] |-> !sclk_oe_n;
  endproperty
  a_master_drives: assert property (p_master_drives) else $error("master clock off"); // RQ1

  property p_slave_listens;
    @(posedge pclk) disable iff (!presetn)
    ctrl[spm_pkg::ROLE_BIT] |-> (sclk_oe_n && frame_oe_n);
  endproperty
  a_slave_listens: assert property (p_slave_listens) else $error("slave drove clock"); // RQ1

  property p_sod;
    @(posedge pclk) disable iff (!presetn)
    (ctrl[spm_pkg::ROLE_BIT] && ctrl[spm_pkg::SOD_BIT]) |-> tx_oe_n;
  endproperty
  a_sod: assert property (p_sod) else $error("disabled slave output driven"); // RQ5

  property p_loop;
    @(posedge pclk) disable iff (!presetn) ctrl[spm_pkg::LOOPBACK_BIT] |-> tx_oe_n;
  endproperty
  a_loop: assert property (p_loop) else $error("pin driven in loopback"); // RQ8

  c_master: cover property (@(posedge pclk) disable iff (!presetn)
    rx_valid && !ctrl[spm_pkg::ROLE_BIT]);
  c_slave: cover property (@(posedge pclk) disable iff (!presetn)
    rx_valid && ctrl[spm_pkg::ROLE_BIT]);
  c_loop: cover property (@(posedge pclk) disable iff (!presetn)
    rx_valid && ctrl[spm_pkg::LOOPBACK_BIT]);
endmodule
`default_nettype wire

//--- bench/spm_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side serial device: slave while the port is master, master otherwise
module spm_far_end (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control
  input  wire logic       drive_clk,
  input  wire logic       go,
  input  wire logic [7:0] out_byte,
  output logic      [7:0] got,
  // Port pins
  input  wire logic       dut_sclk,
  input  wire logic       dut_frame,
  input  wire logic       dut_tx,
  input  wire logic       dut_tx_oe_n,
  output logic            sclk,
  output logic            frame_n,
  output logic            mosi
);
  logic [6:0] cnt;
  logic [7:0] sh;
  logic       pc;
  logic       pf;
  logic       c;
  logic       f;
  logic       txw;
  // Clock only runs inside a frame, eight pulses, each four cycles high in an eight-cycle period
  assign frame_n = !(cnt != 7'h00 && cnt < 7'h46);
  assign sclk    = cnt >= 7'h04 && cnt < 7'h44 && cnt[2];
  assign c       = drive_clk ? sclk : dut_sclk;
  assign f       = drive_clk ? frame_n : dut_frame;
  // Undriven line shows noise, never a held value
  assign txw     = dut_tx_oe_n ? ~mosi : dut_tx;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 7'h00;
      pc <= 1'b0;
      pf <= 1'b1;
      mosi <= 1'b0;
      sh <= 8'h00;
      got <= 8'h00;
    end
    else
    begin
      pc <= c;
      pf <= f;
      if (go && cnt == 7'h00)
        cnt <= 7'h01;
      else if (cnt != 7'h00)
        cnt <= (cnt == 7'h48) ? 7'h00 : cnt + 7'h01;
      if (f)
        mosi <= ~mosi;
      else if (pf)
      begin
        sh <= out_byte;
        mosi <= out_byte[7];
      end
      else if (!c && pc)
      begin
        sh <= {sh[6:0], 1'b0};
        mosi <= sh[6];
      end
      if (!f && c && !pc)
        got <= {got[6:0], txw};
    end
  end
endmodule
`default_nettype wire

//--- bench/test_serial_port_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_mode_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tx_valid, tx_ready, rx_valid, busy, er, drive_clk, go;
  logic [7:0] tx_word, rx_word, out_byte, got;
  logic sclk_o, sclk_oe_n, sclk_i, frame_o, frame_oe_n, frame_i, tx_o, tx_oe_n, rx_i;
  int fails, n_checks, n_low, n_drv, n_rx, m;
  spm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_word(rx_word), .busy(busy), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .sclk_i(sclk_i), .frame_o(frame_o), .frame_oe_n(frame_oe_n),
    .frame_i(frame_i), .tx_o(tx_o), .tx_oe_n(tx_oe_n), .rx_i(rx_i));
  spm_far_end far_u (.pclk(pclk), .presetn(presetn), .drive_clk(drive_clk), .go(go),
    .out_byte(out_byte), .got(got), .dut_sclk(sclk_o), .dut_frame(frame_o),
    .dut_tx(tx_o), .dut_tx_oe_n(tx_oe_n), .sclk(sclk_i), .frame_n(frame_i), .mosi(rx_i));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(negedge pclk)
  begin
    n_low += (frame_o === 1'b0);
    n_drv += (tx_oe_n === 1'b0);
    n_rx += (rx_valid === 1'b1);
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      fails++;
      $display("[ERR] wait expected done seen timeout");
      report_and_stop;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 200);
    tmo(n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Offer one word, start the far master if it clocks, wait for the received word
  // The word is taken at the edge after tx_ready shows; holding valid longer starts a second frame
  task automatic xfer(input logic [7:0] w);
    int n;
    n = 0;
    @(posedge pclk);
    tx_word <= w;
    tx_valid <= 1'b1;
    go <= drive_clk;
    do begin @(negedge pclk); n++; end while (tx_ready !== 1'b1 && n < 200);
    tmo(n);
    @(posedge pclk);
    tx_valid <= 1'b0;
    go <= 1'b0;
    n = 0;
    do begin @(negedge pclk); n++; end while (rx_valid !== 1'b1 && n < 200);
    tmo(n);
    @(posedge pclk);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, go, drive_clk} = '0;
    {tx_valid, tx_word, fails, n_checks, n_low, n_drv, n_rx} = '0;
    out_byte = 8'ha5;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    chk("idle_pins", 2'b10, {frame_o, sclk_o});
    tx_valid <= 1'b1;
    m = n_low;
    repeat (20) @(posedge pclk);
    tx_valid <= 1'b0;
    chk("frames_off", 32'h0, 32'(n_low - m));
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, 12'h004, 32'hffff_fff2);
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl_read", 32'h2, rd);
    xfer(8'h3c);
    chk("master_rx", 32'ha5, rx_word);
    chk("master_tx", 32'h3c, got);
    tx_valid <= 1'b1;
    repeat (20) @(posedge pclk);
    tx_valid <= 1'b0;
    m = n_rx;
    apb(1'b1, 12'h004, 32'h0);
    repeat (100) @(posedge pclk);
    chk("abort_rx", 32'h0, 32'(n_rx - m));
    chk("abort_frame", 32'h1, 32'(frame_o));
    chk("abort_busy", 32'h0, 32'(busy));
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h004, 32'h3);
    xfer(8'h5a);
    chk("loop_rx", 32'h5a, rx_word);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h004, 32'h6);
    drive_clk <= 1'b1;
    out_byte <= 8'h96;
    m = n_drv;
    xfer(8'hc3);
    chk("slave_rx", 32'h96, rx_word);
    chk("slave_tx", 32'hc3, got);
    chk("slave_drives", 32'h1, 32'(n_drv != m));
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h004, 32'he);
    m = n_drv;
    out_byte <= 8'h69;
    xfer(8'h18);
    chk("sod_quiet", 32'h0, 32'(n_drv - m));
    chk("sod_rx", 32'h69, rx_word);
    report_and_stop;
  end
endmodule
`default_nettype wire
